//--- verilog/srzsd_pkg.sv
/*
 * srzsd_pkg: constants for the return-home stall detector block.
 * assumes a single 200 MHz core clock and synchronous active-low reset.
 */
package srzsd_pkg;
    // ========================================================
    // mode codes: {integrate_select, drive_coil_select}
    typedef enum logic [1:0]
    {
        SRZSD_BLANK_NODRIVE = 2'h0,
        SRZSD_BLANK_DRIVE = 2'h1,
        SRZSD_CONVERT = 2'h2,
        SRZSD_INTEGRATE = 2'h3
    } srzsd_mode_t;

    // ========================================================
    // coil bridge states
    typedef enum logic [1:0]
    {
        SRZSD_COIL_FLOAT = 2'h0,
        SRZSD_COIL_DRIVE = 2'h1,
        SRZSD_COIL_RECIRC = 2'h2,
        SRZSD_COIL_OPEN = 2'h3
    } srzsd_coil_t;

    // ========================================================
    // widths, limits and reset values
    localparam int SRZSD_ACC_W = 16;
    localparam int SRZSD_CNT_W = 16;
    localparam logic [15:0] SRZSD_ACC_RESET = 16'h0000;
    localparam logic [15:0] SRZSD_ACC_MAX = 16'h7fff;
    localparam logic [15:0] SRZSD_ACC_MIN = 16'h8000;
    localparam logic [15:0] SRZSD_CNT_ZERO = 16'h0000;
    localparam logic [1:0] SRZSD_STEP_MAX = 2'h3;
    // sample prescale base: bus / (8 * 2^sel)
    localparam int SRZSD_SAMPLE_BASE_LOG2 = 3;
    localparam logic [6:0] SRZSD_PRE_ZERO = 7'h00;
    // modulus counter clock divides: 64 or 512
    localparam logic [8:0] SRZSD_MOD_DIV_FAST = 9'h03f;
    localparam logic [8:0] SRZSD_MOD_DIV_SLOW = 9'h1ff;
endpackage : srzsd_pkg

//--- verilog/srzsd_modcnt.sv
/*
 * srzsd_modcnt: 16-bit modulus down-counter with its own prescaler.
 * assumes the parent gates counting with a run level for low power.
 */
`timescale 1ns/1ps
module srzsd_modcnt
    import srzsd_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic run_in,
    input wire logic slow_sel_in,
    input wire logic load_in,
    input wire logic [15:0] load_val_in,
    output logic [15:0] count_out,
    output logic zero_out
);
    logic [8:0] pre;
    logic [8:0] next_pre;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic tick;

    // ========================================================
    // divider tick and down count; halted while run is low
    always_comb
    begin
        tick = run_in && (pre == (slow_sel_in ? SRZSD_MOD_DIV_SLOW
                                              : SRZSD_MOD_DIV_FAST));
        next_pre = pre;
        next_cnt = cnt;
        if (run_in)
        begin
            next_pre = tick ? 9'h000 : pre + 9'h001;
        end
        if (load_in)
        begin
            next_cnt = load_val_in; // R10
        end
        else if (tick && cnt != SRZSD_CNT_ZERO)
        begin
            next_cnt = cnt - 16'h0001; // R10
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            pre <= 9'h000;
            cnt <= SRZSD_CNT_ZERO;
        end
        else
        begin
            pre <= next_pre;
            cnt <= next_cnt;
        end
    end

    assign count_out = cnt;
    assign zero_out = (cnt == SRZSD_CNT_ZERO);

    // ========================================================
    // counter only moves when running or loading
    property p_halt;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (!run_in && !load_in) |=> (cnt == $past(cnt));
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved halted"); // R11
endmodule : srzsd_modcnt

//--- verilog/srzsd_core.sv
/*
 * srzsd_core: return-home stall detector control and detect logic.
 * assumes software steps the step value and mode bits directly;
 * converter sample arrives as a one-bit up/down decision.
 */
`timescale 1ns/1ps
// Behaviour
// R1: integrate and drive-coil bits decode into four modes.
// R2: blank-no-drive masks one coil, recirculates it, disconnects the other.
// R3: blank-no-drive holds accumulator zero and converter reset.
// R4: blank-drive masks, recirculates one coil, drives other, accumulator zero.
// R5: conversion routes one coil to converter; both coils disconnected.
// R6: integration routes one coil to converter and drives the other.
// R7: offset compensation applied when counter times integration.
// R8: software steps value up for ccw, down for cw, wrapping.
// R9: samples accumulate into a 16-bit signed accumulator.
// R10: 16-bit modulus down-counter times blanking and integration.
// R11: stop powers down converter and halts counter clock.
// R12: wait with powerdown bit does the same as stop; the code also recirculates both coils in that wait, but not in stop.
// R13: cleared power-up bit powers down the converter.
// R14: software toggles motor select to service a second motor.
// R15: enable bit gives coil control; clear leaves coils floating.
// R16: accumulator saturates at 0x7fff and 0x8000 and holds.
// R17: step value picks the measured and the driven coil.
module srzsd_core
    import srzsd_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic integrate_select_in,
    input wire logic drive_coil_select_in,
    input wire logic coil_control_enable_in,
    input wire logic converter_power_up_in,
    input wire logic wait_mode_powerdown_in,
    input wire logic motor_select_in,
    input wire logic stop_mode_in,
    input wire logic wait_mode_in,
    input wire logic [1:0] step_in,
    input wire logic [1:0] sample_sel_in,
    input wire logic mod_slow_in,
    input wire logic mod_load_in,
    input wire logic [15:0] mod_load_val_in,
    input wire logic offset_comp_en_in,
    input wire logic sd_sample_in,
    output logic [1:0] sine_coil_out,
    output logic [1:0] cosine_coil_out,
    output logic sine_measured_out,
    output logic step_positive_out,
    output logic motor_select_out,
    output logic converter_power_out,
    output logic converter_reset_out,
    output logic [15:0] accumulator_out,
    output logic acc_overflow_out,
    output logic [15:0] mod_count_out,
    output logic mod_zero_out
);
    srzsd_mode_t mode;
    logic measure_sine;
    logic low_power;
    logic conv_on;
    logic [1:0] sample_sel;
    logic [1:0] next_sample_sel;
    logic [6:0] pre;
    logic [6:0] next_pre;
    logic sample_tick;
    logic [15:0] acc;
    logic [15:0] next_acc;
    logic ovf;
    logic next_ovf;
    logic chop;
    logic next_chop;
    logic [1:0] sine_q;
    logic [1:0] next_sine;
    logic [1:0] cos_q;
    logic [1:0] next_cos;
    logic meas_q;
    logic sgn_q;
    logic next_sgn;
    logic mod_zero;

    // saturating add of +1 or -1
    function automatic logic [16:0] srzsd_sat_step(
        input logic [15:0] a,
        input logic up
    );
        logic [16:0] r;
        r = {1'b0, a};
        if (up && a == SRZSD_ACC_MAX)
        begin
            r = {1'b1, SRZSD_ACC_MAX};
        end
        else if (!up && a == SRZSD_ACC_MIN)
        begin
            r = {1'b1, SRZSD_ACC_MIN};
        end
        else
        begin
            r = {1'b0, up ? a + 16'h0001 : a - 16'h0001};
        end
        return r;
    endfunction : srzsd_sat_step

    // ========================================================
    // mode decode and power
    assign mode = srzsd_mode_t'({integrate_select_in,
                                 drive_coil_select_in}); // R1
    assign measure_sine = step_in[0]; // R17
    // both stop and wait-with-powerdown freeze the analog path
    assign low_power = stop_mode_in
        || (wait_mode_in && wait_mode_powerdown_in); // R11 R12
    assign conv_on = converter_power_up_in && !low_power; // R13

    // ========================================================
    // coil state next values, registered so outputs glitch-free
    always_comb
    begin
        srzsd_coil_t meas_c;
        srzsd_coil_t other_c;
        meas_c = SRZSD_COIL_FLOAT;
        other_c = SRZSD_COIL_FLOAT;
        unique case (mode)
            SRZSD_BLANK_NODRIVE:
            begin
                meas_c = SRZSD_COIL_RECIRC; // R2
                other_c = SRZSD_COIL_OPEN; // R2
            end
            SRZSD_BLANK_DRIVE:
            begin
                meas_c = SRZSD_COIL_RECIRC; // R4
                other_c = SRZSD_COIL_DRIVE; // R4
            end
            SRZSD_CONVERT:
            begin
                meas_c = SRZSD_COIL_OPEN; // R5
                other_c = SRZSD_COIL_OPEN; // R5
            end
            SRZSD_INTEGRATE:
            begin
                meas_c = SRZSD_COIL_OPEN; // R6
                other_c = SRZSD_COIL_DRIVE; // R6
            end
        endcase
        // low power in wait recirculates both coils
        if (low_power && !stop_mode_in)
        begin
            meas_c = SRZSD_COIL_RECIRC;
            other_c = SRZSD_COIL_RECIRC;
        end
        if (!coil_control_enable_in)
        begin
            meas_c = SRZSD_COIL_FLOAT; // R15
            other_c = SRZSD_COIL_FLOAT; // R15
        end
        next_sine = measure_sine ? meas_c : other_c; // R17
        next_cos = measure_sine ? other_c : meas_c; // R17
        next_sgn = step_in[1]; // R8
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            sine_q <= SRZSD_COIL_FLOAT;
            cos_q <= SRZSD_COIL_FLOAT;
            meas_q <= 1'b0;
            sgn_q <= 1'b0;
        end
        else
        begin
            sine_q <= next_sine;
            cos_q <= next_cos;
            meas_q <= measure_sine;
            sgn_q <= next_sgn;
        end
    end

    // ========================================================
    // sample prescaler: bus / (8 << sel); sel only latched
    // while not integrating so the rate never shifts mid-run
    always_comb
    begin
        next_sample_sel = integrate_select_in ? sample_sel : sample_sel_in;
        sample_tick = (pre == SRZSD_PRE_ZERO) && conv_on
            && integrate_select_in;
        next_pre = pre;
        if (!integrate_select_in || !conv_on)
        begin
            next_pre = 7'((1 << (SRZSD_SAMPLE_BASE_LOG2 + sample_sel)) - 1);
        end
        else if (sample_tick)
        begin
            next_pre = 7'((1 << (SRZSD_SAMPLE_BASE_LOG2 + sample_sel)) - 1);
        end
        else
        begin
            next_pre = pre - 7'h01;
        end
    end

    // ========================================================
    // accumulator with saturation and chopper offset cancel;
    // chopping swaps sample sign each sample when the counter
    // is timing integration, so converter offset averages out
    always_comb
    begin
        logic [16:0] s;
        logic up;
        s = {1'b0, acc};
        up = sd_sample_in;
        next_acc = acc;
        next_ovf = ovf;
        next_chop = chop;
        if (!integrate_select_in)
        begin
            next_acc = SRZSD_ACC_RESET; // R3 R4
            next_ovf = 1'b0;
            next_chop = 1'b0;
        end
        else if (sample_tick && !ovf)
        begin
            if (offset_comp_en_in && !mod_zero)
            begin
                up = sd_sample_in ^ chop; // R7
                next_chop = !chop; // R7
            end
            s = srzsd_sat_step(acc, up); // R9
            next_acc = s[15:0]; // R9
            next_ovf = s[16]; // R16
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rst_b_in)
        begin
            pre <= SRZSD_PRE_ZERO;
            sample_sel <= 2'h0;
            acc <= SRZSD_ACC_RESET;
            ovf <= 1'b0;
            chop <= 1'b0;
        end
        else
        begin
            pre <= next_pre;
            sample_sel <= next_sample_sel;
            acc <= next_acc;
            ovf <= next_ovf;
            chop <= next_chop;
        end
    end

    // ========================================================
    // modulus counter, clock halted in low power
    srzsd_modcnt u_modcnt
    (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .run_in(!low_power), // R11 R12
        .slow_sel_in(mod_slow_in),
        .load_in(mod_load_in),
        .load_val_in(mod_load_val_in),
        .count_out(mod_count_out),
        .zero_out(mod_zero)
    );

    // ========================================================
    // outputs
    assign sine_coil_out = sine_q;
    assign cosine_coil_out = cos_q;
    assign sine_measured_out = meas_q;
    assign step_positive_out = sgn_q;
    assign motor_select_out = motor_select_in; // R14
    assign converter_power_out = conv_on; // R13
    assign converter_reset_out = !integrate_select_in; // R3
    assign accumulator_out = acc;
    assign acc_overflow_out = ovf;
    assign mod_zero_out = mod_zero;

    // ========================================================
    // checks
    property p_blank_zero;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        !integrate_select_in |=> (acc == SRZSD_ACC_RESET);
    endproperty
    a_blank_zero: assert property (p_blank_zero) else $error("acc not zero"); // R3

    property p_float;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        !coil_control_enable_in |=>
            (sine_q == SRZSD_COIL_FLOAT && cos_q == SRZSD_COIL_FLOAT);
    endproperty
    a_float: assert property (p_float) else $error("coils driven"); // R15

    property p_convert;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (coil_control_enable_in && !low_power && mode == SRZSD_CONVERT)
            |=> (sine_q == SRZSD_COIL_OPEN && cos_q == SRZSD_COIL_OPEN);
    endproperty
    a_convert: assert property (p_convert) else $error("convert coils"); // R5

    property p_drive;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (coil_control_enable_in && !low_power && mode == SRZSD_INTEGRATE
            && step_in[0]) |=> (cos_q == SRZSD_COIL_DRIVE);
    endproperty
    a_drive: assert property (p_drive) else $error("other coil idle"); // R6

    property p_nodrive;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (coil_control_enable_in && !low_power
            && mode == SRZSD_BLANK_NODRIVE && !step_in[0])
            |=> (cos_q == SRZSD_COIL_RECIRC && sine_q == SRZSD_COIL_OPEN);
    endproperty
    a_nodrive: assert property (p_nodrive) else $error("blank coils"); // R2

    property p_sat;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (ovf && integrate_select_in) |=> $stable(acc);
    endproperty
    a_sat: assert property (p_sat) else $error("acc left rail"); // R16

    property p_power;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (!converter_power_up_in || stop_mode_in) |-> !converter_power_out;
    endproperty
    a_power: assert property (p_power) else $error("converter on"); // R13

    property p_step;
        @(posedge core_clk_in) disable iff (!rst_b_in)
        (integrate_select_in && !sample_tick && $past(integrate_select_in))
            |=> (acc == $past(acc) || $past(sample_tick));
    endproperty
    a_step: assert property (p_step) else $error("acc moved off tick"); // R9
endmodule : srzsd_core

//--- verification/srzsd_coil_model.sv
/*
 * srzsd_coil_model: behavioural stepper coils behind the two bridges.
 * assumes the bench sets the back-emf sign of the measured coil.
 */
`timescale 1ns/1ps
module srzsd_coil_model
(
    input wire logic core_clk_in,
    input wire logic [1:0] sine_coil_in,
    input wire logic [1:0] cosine_coil_in,
    input wire logic sine_measured_in,
    input wire logic converter_power_in,
    input wire logic emf_pos_in,
    output logic sd_sample_out
);
    // ========================================================
    // converter decision
    logic junk;
    logic [1:0] measured;

    // flips every cycle so an unpowered converter never looks settled
    initial junk = 1'b0;
    always @(posedge core_clk_in)
    begin
        junk <= ~junk;
    end

    // a driven coil swamps its own back emf, so no clean sign then
    always_comb
    begin
        measured = sine_measured_in ? sine_coil_in : cosine_coil_in;
        if (converter_power_in && measured != 2'h1)
            sd_sample_out = emf_pos_in;
        else
            sd_sample_out = junk;
    end
endmodule : srzsd_coil_model

//--- verification/srzsd_core_tb_top.sv
/*
 * srzsd_core_tb_top: directed bench for the stall detector core.
 * assumes the coil model closes the loop on the converter input.
 */
`timescale 1ns/1ps
module srzsd_core_tb_top
    import srzsd_pkg::*;
();
    // ========================================================
    // signals
    logic core_clk_in, rst_b_in, integrate_select_in, drive_coil_select_in;
    logic coil_control_enable_in, converter_power_up_in, motor_select_in;
    logic wait_mode_powerdown_in, stop_mode_in, wait_mode_in, mod_slow_in;
    logic mod_load_in, offset_comp_en_in, sd_sample_in, emf_pos;
    logic [1:0] step_in, sample_sel_in, sine_coil_out, cosine_coil_out;
    logic [15:0] mod_load_val_in, accumulator_out, mod_count_out;
    logic sine_measured_out, step_positive_out, motor_select_out;
    logic converter_power_out, converter_reset_out, acc_overflow_out;
    logic mod_zero_out;
    int checks = 0;
    int failures = 0;

    srzsd_core dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .integrate_select_in(integrate_select_in),
        .drive_coil_select_in(drive_coil_select_in),
        .coil_control_enable_in(coil_control_enable_in),
        .converter_power_up_in(converter_power_up_in),
        .wait_mode_powerdown_in(wait_mode_powerdown_in),
        .motor_select_in(motor_select_in), .stop_mode_in(stop_mode_in),
        .wait_mode_in(wait_mode_in), .step_in(step_in),
        .sample_sel_in(sample_sel_in), .mod_slow_in(mod_slow_in),
        .mod_load_in(mod_load_in), .mod_load_val_in(mod_load_val_in),
        .offset_comp_en_in(offset_comp_en_in), .sd_sample_in(sd_sample_in),
        .sine_coil_out(sine_coil_out), .cosine_coil_out(cosine_coil_out),
        .sine_measured_out(sine_measured_out),
        .step_positive_out(step_positive_out),
        .motor_select_out(motor_select_out),
        .converter_power_out(converter_power_out),
        .converter_reset_out(converter_reset_out),
        .accumulator_out(accumulator_out),
        .acc_overflow_out(acc_overflow_out),
        .mod_count_out(mod_count_out), .mod_zero_out(mod_zero_out));

    srzsd_coil_model coil (.core_clk_in(core_clk_in),
        .sine_coil_in(sine_coil_out), .cosine_coil_in(cosine_coil_out),
        .sine_measured_in(sine_measured_out),
        .converter_power_in(converter_power_out), .emf_pos_in(emf_pos),
        .sd_sample_out(sd_sample_in));

    // ========================================================
    // helpers
    initial
    begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : tick

    task automatic chk(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // bounded wait for the next counter step, returns cycles taken
    task automatic wait_change(output int gap);
        logic [15:0] v;
        v = mod_count_out;
        gap = 0;
        while (mod_count_out === v && gap < 1200)
        begin
            tick(1);
            gap++;
        end
    endtask : wait_change

    function automatic logic [1:0] coil_exp(input logic [1:0] m,
        input logic en, input logic me);
        if (!en)
            return SRZSD_COIL_FLOAT;
        case (m)
            2'h0: return me ? SRZSD_COIL_RECIRC : SRZSD_COIL_OPEN;
            2'h1: return me ? SRZSD_COIL_RECIRC : SRZSD_COIL_DRIVE;
            2'h2: return SRZSD_COIL_OPEN;
            default: return me ? SRZSD_COIL_OPEN : SRZSD_COIL_DRIVE;
        endcase
    endfunction : coil_exp

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    // ========================================================
    // scenarios
    task automatic t_reset();
        chk("sine_rst", 16'(sine_coil_out), 16'h0000);
        chk("cos_rst", 16'(cosine_coil_out), 16'h0000);
        chk("acc_rst", accumulator_out, 16'h0000);
        chk("ovf_rst", 16'(acc_overflow_out), 16'h0000);
        chk("cnt_rst", mod_count_out, 16'h0000);
    endtask : t_reset

    // every mode, enable level and step, ccw up then cw down with wraps
    task automatic t_modes();
        logic [1:0] s;
        for (int e = 0; e < 2; e++)
            for (int m = 0; m < 4; m++)
                for (int k = 0; k < 8; k++)
                begin
                    s = (k < 5) ? 2'(k) : 2'(8 - k);
                    coil_control_enable_in = 1'(e);
                    {integrate_select_in, drive_coil_select_in} = 2'(m);
                    step_in = s;
                    motor_select_in = 1'(k);
                    tick(1);
                    chk("sine", 16'(sine_coil_out),
                        16'(coil_exp(2'(m), 1'(e), s[0])));
                    chk("cos", 16'(cosine_coil_out),
                        16'(coil_exp(2'(m), 1'(e), ~s[0])));
                    chk("measured", 16'(sine_measured_out), 16'(s[0]));
                    chk("cv_rst", 16'(converter_reset_out),
                        16'(m < 2));
                    chk("msel", 16'(motor_select_out), 16'(k[0]));
                    chk("sign", 16'(step_positive_out), 16'(s[1]));
                end
    endtask : t_modes

    // each sample rate, alternating emf sign; rate change mid-run ignored
    task automatic t_accum();
        for (int sel = 0; sel < 4; sel++)
        begin
            integrate_select_in = 1'b0;
            sample_sel_in = 2'(sel);
            emf_pos = sel[0];
            tick(2);
            chk("acc_clr", accumulator_out, 16'h0000);
            integrate_select_in = 1'b1;
            tick(1);
            sample_sel_in = 2'(3 - sel);
            tick(4 * (8 << sel) - 1);
            chk("acc_sum", accumulator_out,
                sel[0] ? 16'h0004 : 16'hfffc);
        end
        integrate_select_in = 1'b0;
        converter_power_up_in = 1'b0;
        tick(2);
        chk("acc_clr2", accumulator_out, 16'h0000);
        chk("cv_off", 16'(converter_power_out), 16'h0000);
        integrate_select_in = 1'b1;
        tick(64);
        chk("acc_off", accumulator_out, 16'h0000);
        integrate_select_in = 1'b0;
        converter_power_up_in = 1'b1;
        tick(2);
    endtask : t_accum

    // constant emf with compensation on must not sum plainly
    task automatic t_offset();
        mod_load_val_in = 16'hffff;
        mod_load_in = 1'b1;
        offset_comp_en_in = 1'b1;
        emf_pos = 1'b1;
        sample_sel_in = 2'h0;
        tick(2);
        mod_load_in = 1'b0;
        integrate_select_in = 1'b1;
        tick(64);
        // eight chopped samples of one sign cancel exactly
        chk("chop", accumulator_out, 16'h0000);
        integrate_select_in = 1'b0;
        offset_comp_en_in = 1'b0;
        tick(2);
    endtask : t_offset

    task automatic t_modcnt();
        int gap;
        logic [15:0] v;
        coil_control_enable_in = 1'b1;
        for (int slow = 0; slow < 2; slow++)
        begin
            mod_slow_in = 1'(slow);
            mod_load_val_in = 16'h0005;
            mod_load_in = 1'b1;
            tick(1);
            mod_load_in = 1'b0;
            chk("load", mod_count_out, 16'h0005);
            wait_change(gap);
            wait_change(gap);
            chk("gap", 16'(gap), slow ? 16'h0200 : 16'h0040);
        end
        mod_slow_in = 1'b0;
        // stop, wait with powerdown, then plain wait that keeps running
        for (int p = 0; p < 3; p++)
        begin
            stop_mode_in = (p == 0);
            wait_mode_in = (p != 0);
            wait_mode_powerdown_in = (p == 1);
            tick(1);
            chk("lp_pwr", 16'(converter_power_out), 16'(p == 2));
            v = mod_count_out;
            tick(200);
            if (p < 2)
                chk("lp_freeze", mod_count_out, v);
            else
                chk("lp_run", 16'(mod_count_out != v), 16'h0001);
        end
        wait_mode_powerdown_in = 1'b1;
        tick(1);
        chk("wait_sin", 16'(sine_coil_out), 16'(SRZSD_COIL_RECIRC));
        chk("wait_cos", 16'(cosine_coil_out), 16'(SRZSD_COIL_RECIRC));
        wait_mode_powerdown_in = 1'b0;
        wait_mode_in = 1'b0;
        // plain wait ran the count down to zero, so reload before timing
        mod_load_val_in = 16'h0005;
        mod_load_in = 1'b1;
        tick(1);
        mod_load_in = 1'b0;
        wait_change(gap);
        wait_change(gap);
        chk("run_gap", 16'(gap), 16'h0040);
        mod_load_val_in = 16'h0002;
        mod_load_in = 1'b1;
        tick(1);
        mod_load_in = 1'b0;
        tick(400);
        chk("cnt_end", mod_count_out, 16'h0000);
        chk("zero", 16'(mod_zero_out), 16'h0001);
    endtask : t_modcnt

    // ========================================================
    // main sequence and watchdog
    initial
    begin
        rst_b_in = 1'b0;
        {integrate_select_in, drive_coil_select_in} = 2'h0;
        {coil_control_enable_in, wait_mode_powerdown_in} = 2'h0;
        {motor_select_in, stop_mode_in, wait_mode_in} = 3'h0;
        {mod_slow_in, mod_load_in, offset_comp_en_in} = 3'h0;
        {step_in, sample_sel_in} = 4'h0;
        converter_power_up_in = 1'b1;
        mod_load_val_in = 16'h0000;
        emf_pos = 1'b1;
        repeat (16) @(posedge core_clk_in);
        @(negedge core_clk_in);
        rst_b_in = 1'b1;
        tick(1);
        t_reset();
        t_modes();
        t_accum();
        t_offset();
        t_modcnt();
        end_of_test();
    end

    // about twenty times the expected run length
    initial
    begin
        #300000;
        failures++;
        end_of_test();
    end
endmodule : srzsd_core_tb_top
